// File: hw/irq_timer_pkg.sv
package irq_timer_pkg;

  localparam int INSTR_W = 10;
  localparam int ACC_W = 4;
  localparam int CTL_W = 4;
  localparam int TCC_W = 2;

  // instruction codes
  localparam logic [9:0] CODE_IRQ_MASK = 10'h004;
  localparam logic [9:0] CODE_IRQ_UNMASK = 10'h005;
  localparam logic [9:0] CODE_SKIP_EXT = 10'h038;
  localparam logic [9:0] CODE_SKIP_PIN = 10'h03a;
  localparam logic [9:0] CODE_RD_IC_A = 10'h054;
  localparam logic [9:0] CODE_WR_IC_A = 10'h03f;
  localparam logic [9:0] CODE_RD_IC_B = 10'h253;
  localparam logic [9:0] CODE_WR_IC_B = 10'h217;
  localparam logic [9:0] CODE_SKIP_TA = 10'h280;
  localparam logic [9:0] CODE_SKIP_TB = 10'h281;
  localparam logic [9:0] CODE_RD_TC_A = 10'h24b;
  localparam logic [9:0] CODE_WR_TC_A = 10'h20e;
  localparam logic [9:0] CODE_RD_TC_B = 10'h24c;
  localparam logic [9:0] CODE_WR_TC_B = 10'h20f;
  localparam logic [9:0] CODE_RD_TC_C = 10'h24d;
  localparam logic [9:0] CODE_WR_TC_C = 10'h210;

  localparam int PIN_LEVEL_SELECT_BIT = 2;

  // apb register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATE = 8'h04;
  localparam logic [7:0] OFF_CTL_VIEW = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // control register
  localparam int CONTROL_EXEC_EN_BIT = 0;
  localparam logic CONTROL_EXEC_EN_RST = 1'b1;

  // state register fields
  localparam int STATE_GIE_BIT = 0;
  localparam int STATE_EXT_BIT = 1;
  localparam int STATE_TA_BIT = 2;
  localparam int STATE_TB_BIT = 3;
  localparam int STATE_PIN_BIT = 4;
  localparam int STATE_SKIP_PEND_BIT = 5;

  // irq status and mask layout
  localparam int EVT_N = 3;
  localparam int EVT_SKIP_TAKEN = 0;
  localparam int EVT_SUPPRESSED = 1;
  localparam int EVT_GIE_CHANGE = 2;
  localparam logic [EVT_N-1:0] IRQ_MASK_RST = 3'h0;

  localparam logic [3:0] CTL_RST = 4'h0;
  localparam logic [1:0] TCC_RST = 2'h0;

  typedef enum {
    OP_NONE, OP_IRQ_MASK, OP_IRQ_UNMASK, OP_SKIP_EXT, OP_SKIP_PIN,
    OP_RD_IC_A, OP_WR_IC_A, OP_RD_IC_B, OP_WR_IC_B, OP_SKIP_TA, OP_SKIP_TB,
    OP_RD_TC_A, OP_WR_TC_A, OP_RD_TC_B, OP_WR_TC_B, OP_RD_TC_C, OP_WR_TC_C
  } op_t;

  typedef struct packed {
    logic [1:0] timer_control_c;
    logic [3:0] timer_control_b;
    logic [3:0] timer_control_a;
    logic [3:0] irq_control_b;
    logic [3:0] irq_control_a;
  } ctl_regs_t;

  typedef struct packed {
    logic [3:0] wmask;
    logic [3:0] wdata;
    logic wr;
  } acc_wr_t;

endpackage

// File: hw/irq_timer_ctrl_instr_exec.sv
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// [RL1] code 004 clears global interrupt enable
// [RL2] code 005 sets global interrupt enable
// [RL3] code 038 skips on external flag, clears it
// [RL4] code 03A skips on pin level, polarity selectable
// [RL5] code 054 copies irq control a to accumulator
// [RL6] code 03F loads irq control a from accumulator
// [RL7] code 253 copies irq control b to accumulator
// [RL8] code 217 loads irq control b from accumulator
// [RL9] code 280 skips on timer a flag, clears it
// [RL10] code 281 skips on timer b flag, clears it
// [RL11] code 24B copies timer control a to accumulator
// [RL12] code 20E loads timer control a from accumulator
// [RL13] code 24C copies timer control b to accumulator
// [RL14] code 20F loads timer control b from accumulator
// [RL15] code 24D copies timer control c to bits 1..0
// [RL16] code 210 loads timer control c from bits 1..0
// [RL17] skipped instruction is fetched but changes nothing
// [RL18] skip flagged with test, flag cleared only on skip
module irq_timer_ctrl_instr_exec (
  input wire logic core_clk, // core instruction clock
  input wire logic rst, // synchronous reset, active high
  input wire logic instr_valid, // one instruction offered this cycle
  input wire logic [irq_timer_pkg::INSTR_W-1:0] instr, // instruction code
  input wire logic [irq_timer_pkg::ACC_W-1:0] acc_in, // accumulator contents
  input wire logic ext_request_set, // external request event pulse
  input wire logic timer_a_set, // timer a underflow pulse
  input wire logic timer_b_set, // timer b event pulse
  input wire logic ext_pin, // external request pin, asynchronous
  output irq_timer_pkg::acc_wr_t acc_wr, // accumulator write request
  output logic skip_req, // skip request toward sequencer
  output logic irq_global_enable, // global interrupt enable
  output logic ext_request_flag, // external request flag
  output logic timer_a_flag, // timer a flag
  output logic timer_b_flag, // timer b flag
  output irq_timer_pkg::ctl_regs_t ctl_regs, // control registers
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq // level interrupt
);
  import irq_timer_pkg::*;

  op_t op;
  logic ex;
  logic exec_en_q;
  logic skip_pend_q;
  logic skip_d;
  logic pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
  logic gie_q, ext_q, ta_q, tb_q;
  ctl_regs_t ctl_q;
  acc_wr_t acc_q;
  logic skip_q;
  logic [EVT_N-1:0] status_q, mask_q, evt;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  logic apb_wr, apb_setup, addr_ok;

  // an instruction executes unless disabled or under a pending skip
  assign ex = instr_valid & exec_en_q & ~skip_pend_q; // RL17

  always_comb begin
    case (instr)
      CODE_IRQ_MASK: op = OP_IRQ_MASK;
      CODE_IRQ_UNMASK: op = OP_IRQ_UNMASK;
      CODE_SKIP_EXT: op = OP_SKIP_EXT;
      CODE_SKIP_PIN: op = OP_SKIP_PIN;
      CODE_RD_IC_A: op = OP_RD_IC_A;
      CODE_WR_IC_A: op = OP_WR_IC_A;
      CODE_RD_IC_B: op = OP_RD_IC_B;
      CODE_WR_IC_B: op = OP_WR_IC_B;
      CODE_SKIP_TA: op = OP_SKIP_TA;
      CODE_SKIP_TB: op = OP_SKIP_TB;
      CODE_RD_TC_A: op = OP_RD_TC_A;
      CODE_WR_TC_A: op = OP_WR_TC_A;
      CODE_RD_TC_B: op = OP_RD_TC_B;
      CODE_WR_TC_B: op = OP_WR_TC_B;
      CODE_RD_TC_C: op = OP_RD_TC_C;
      CODE_WR_TC_C: op = OP_WR_TC_C;
      default: op = OP_NONE;
    endcase
  end

  // skip decision taken in the decode cycle
  always_comb begin
    skip_d = 1'b0;
    if (ex) begin
      case (op)
        OP_SKIP_EXT: skip_d = ext_q; // RL3
        OP_SKIP_PIN: skip_d = (pin_lvl_q == ctl_q.irq_control_b[PIN_LEVEL_SELECT_BIT]); // RL4
        OP_SKIP_TA: skip_d = ta_q; // RL9
        OP_SKIP_TB: skip_d = tb_q; // RL10
        default: skip_d = 1'b0;
      endcase
    end
  end

  // pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_lvl_q <= pin_s3_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gie_q <= 1'b0;
    end else if (ex && op == OP_IRQ_MASK) begin
      gie_q <= 1'b0; // RL1
    end else if (ex && op == OP_IRQ_UNMASK) begin
      gie_q <= 1'b1; // RL2
    end
  end

  // event flags: a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_q <= 1'b0;
      ta_q <= 1'b0;
      tb_q <= 1'b0;
    end else begin
      if (ext_request_set) begin
        ext_q <= 1'b1;
      end else if (skip_d && op == OP_SKIP_EXT) begin
        ext_q <= 1'b0; // RL3 RL18
      end
      if (timer_a_set) begin
        ta_q <= 1'b1;
      end else if (skip_d && op == OP_SKIP_TA) begin
        ta_q <= 1'b0; // RL9 RL18
      end
      if (timer_b_set) begin
        tb_q <= 1'b1;
      end else if (skip_d && op == OP_SKIP_TB) begin
        tb_q <= 1'b0; // RL10 RL18
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_q <= 1'b0;
      skip_pend_q <= 1'b0;
    end else begin
      skip_q <= skip_d; // RL18
      if (skip_d) begin
        skip_pend_q <= 1'b1;
      end else if (instr_valid) begin
        skip_pend_q <= 1'b0; // RL17
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_q <= '{timer_control_c: TCC_RST, timer_control_b: CTL_RST, timer_control_a: CTL_RST,
                 irq_control_b: CTL_RST, irq_control_a: CTL_RST};
    end else if (ex) begin
      case (op)
        OP_WR_IC_A: ctl_q.irq_control_a <= acc_in; // RL6
        OP_WR_IC_B: ctl_q.irq_control_b <= acc_in; // RL8
        OP_WR_TC_A: ctl_q.timer_control_a <= acc_in; // RL12
        OP_WR_TC_B: ctl_q.timer_control_b <= acc_in; // RL14
        OP_WR_TC_C: ctl_q.timer_control_c <= acc_in[1:0]; // RL16
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_q <= '0;
    end else begin
      acc_q.wr <= 1'b0;
      acc_q.wmask <= 4'hf;
      acc_q.wdata <= 4'h0;
      if (ex) begin
        case (op)
          OP_RD_IC_A: begin
            acc_q.wr <= 1'b1;
            acc_q.wdata <= ctl_q.irq_control_a; // RL5
          end
          OP_RD_IC_B: begin
            acc_q.wr <= 1'b1;
            acc_q.wdata <= ctl_q.irq_control_b; // RL7
          end
          OP_RD_TC_A: begin
            acc_q.wr <= 1'b1;
            acc_q.wdata <= ctl_q.timer_control_a; // RL11
          end
          OP_RD_TC_B: begin
            acc_q.wr <= 1'b1;
            acc_q.wdata <= ctl_q.timer_control_b; // RL13
          end
          OP_RD_TC_C: begin
            acc_q.wr <= 1'b1;
            acc_q.wmask <= 4'h3;
            acc_q.wdata <= {2'h0, ctl_q.timer_control_c}; // RL15
          end
          default: acc_q.wr <= 1'b0;
        endcase
      end
    end
  end

  // apb slave: zero wait states, answer ready in the access phase
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite & pready_q;
  assign addr_ok = (paddr == OFF_CONTROL) || (paddr == OFF_STATE) || (paddr == OFF_CTL_VIEW) ||
                   (paddr == OFF_IRQ_STATUS) || (paddr == OFF_IRQ_MASK);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~addr_ok;
      prdata_q <= 32'h0;
      if (apb_setup && !pwrite) begin
        case (paddr)
          OFF_CONTROL: prdata_q[CONTROL_EXEC_EN_BIT] <= exec_en_q;
          OFF_STATE: begin
            prdata_q[STATE_GIE_BIT] <= gie_q;
            prdata_q[STATE_EXT_BIT] <= ext_q;
            prdata_q[STATE_TA_BIT] <= ta_q;
            prdata_q[STATE_TB_BIT] <= tb_q;
            prdata_q[STATE_PIN_BIT] <= pin_lvl_q;
            prdata_q[STATE_SKIP_PEND_BIT] <= skip_pend_q;
          end
          OFF_CTL_VIEW: prdata_q[$bits(ctl_regs_t)-1:0] <= ctl_q;
          OFF_IRQ_STATUS: prdata_q[EVT_N-1:0] <= status_q;
          OFF_IRQ_MASK: prdata_q[EVT_N-1:0] <= mask_q;
          default: prdata_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      exec_en_q <= CONTROL_EXEC_EN_RST;
      mask_q <= IRQ_MASK_RST;
    end else if (apb_wr) begin
      if (paddr == OFF_CONTROL) begin
        exec_en_q <= pwdata[CONTROL_EXEC_EN_BIT];
      end
      if (paddr == OFF_IRQ_MASK) begin
        mask_q <= pwdata[EVT_N-1:0];
      end
    end
  end

  assign evt[EVT_SKIP_TAKEN] = skip_d;
  assign evt[EVT_SUPPRESSED] = instr_valid & skip_pend_q;
  assign evt[EVT_GIE_CHANGE] = ex & ((op == OP_IRQ_MASK & gie_q) | (op == OP_IRQ_UNMASK & ~gie_q));

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == OFF_IRQ_STATUS) begin
        status_q <= (status_q & ~pwdata[EVT_N-1:0]) | evt;
      end else begin
        status_q <= status_q | evt;
      end
      irq_q <= |((status_q | evt) & mask_q);
    end
  end

  assign acc_wr = acc_q;
  assign skip_req = skip_q;
  assign irq_global_enable = gie_q;
  assign ext_request_flag = ext_q;
  assign timer_a_flag = ta_q;
  assign timer_b_flag = tb_q;
  assign ctl_regs = ctl_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // instruction port: every answer lands exactly one cycle after decode
  chk_mask_clears: assert property (ex && op == OP_IRQ_MASK |=> !irq_global_enable) // RL1
    else $error("global enable not cleared");
  chk_unmask_sets: assert property (ex && op == OP_IRQ_UNMASK |=> irq_global_enable) // RL2
    else $error("global enable not set");
  chk_ext_skip: assert property (ex && op == OP_SKIP_EXT && ext_q && !ext_request_set // RL3
    |=> skip_req && !ext_request_flag)
    else $error("external flag skip wrong");
  chk_ext_set_wins: assert property (ex && op == OP_SKIP_EXT && ext_q && ext_request_set // RL18
    |=> skip_req && ext_request_flag)
    else $error("external flag lost new event");
  chk_ext_noskip: assert property (ex && op == OP_SKIP_EXT && !ext_q |=> !skip_req) // RL18
    else $error("skip without external flag");
  chk_pin_skip: assert property (ex && op == OP_SKIP_PIN // RL4
    |=> skip_req == ($past(pin_lvl_q) == $past(ctl_q.irq_control_b[PIN_LEVEL_SELECT_BIT])))
    else $error("pin level skip wrong");
  chk_timer_skip: assert property (ex && op == OP_SKIP_TA && ta_q && !timer_a_set // RL9
    |=> skip_req && !timer_a_flag)
    else $error("timer a skip wrong");
  chk_timer_a_keep: assert property (ex && op == OP_SKIP_TA && !ta_q |=> !skip_req) // RL9
    else $error("timer a skip without flag");
  chk_timer_b_skip: assert property (ex && op == OP_SKIP_TB && tb_q && !timer_b_set // RL10
    |=> skip_req && !timer_b_flag)
    else $error("timer b skip wrong");
  chk_timer_b_keep: assert property (ex && op == OP_SKIP_TB && !tb_q |=> !skip_req) // RL10
    else $error("timer b skip without flag");
  chk_read_ctl_a: assert property (ex && op == OP_RD_IC_A // RL5
    |=> acc_wr.wr && acc_wr.wdata == $past(ctl_q.irq_control_a))
    else $error("irq control a read wrong");
  chk_read_ctl_b: assert property (ex && op == OP_RD_IC_B // RL7
    |=> acc_wr.wr && acc_wr.wdata == $past(ctl_q.irq_control_b))
    else $error("irq control b read wrong");
  chk_read_tmr_a: assert property (ex && op == OP_RD_TC_A // RL11
    |=> acc_wr.wr && acc_wr.wdata == $past(ctl_q.timer_control_a))
    else $error("timer control a read wrong");
  chk_read_tmr_b: assert property (ex && op == OP_RD_TC_B // RL13
    |=> acc_wr.wr && acc_wr.wdata == $past(ctl_q.timer_control_b))
    else $error("timer control b read wrong");
  chk_read_tmr_c: assert property (ex && op == OP_RD_TC_C // RL15
    |=> acc_wr.wr && acc_wr.wmask == 4'h3 && acc_wr.wdata == {2'h0, $past(ctl_q.timer_control_c)})
    else $error("timer control c read wrong");
  chk_write_ctl_a: assert property (ex && op == OP_WR_IC_A // RL6
    |=> ctl_regs.irq_control_a == $past(acc_in))
    else $error("irq control a load wrong");
  chk_write_ctl_b: assert property (ex && op == OP_WR_IC_B // RL8
    |=> ctl_regs.irq_control_b == $past(acc_in))
    else $error("irq control b load wrong");
  chk_write_tmr_a: assert property (ex && op == OP_WR_TC_A // RL12
    |=> ctl_regs.timer_control_a == $past(acc_in))
    else $error("timer control a load wrong");
  chk_write_tmr_b: assert property (ex && op == OP_WR_TC_B // RL14
    |=> ctl_regs.timer_control_b == $past(acc_in))
    else $error("timer control b load wrong");
  chk_tcc_write: assert property (ex && op == OP_WR_TC_C // RL16
    |=> ctl_regs.timer_control_c == $past(acc_in[1:0]) && $stable(ctl_regs.timer_control_b))
    else $error("timer control c load wrong");
  chk_skip_suppress: assert property (skip_pend_q && instr_valid // RL17
    |=> !acc_wr.wr && !skip_req && $stable(ctl_regs) && $stable(irq_global_enable))
    else $error("skipped instruction took effect");
  chk_exec_disabled: assert property (instr_valid && !exec_en_q
    |=> !acc_wr.wr && !skip_req && $stable(ctl_regs) && $stable(irq_global_enable))
    else $error("instruction ran while disabled");

  // register bus and interrupt
  chk_apb_error: assert property (psel && !penable && !addr_ok |=> pready && pslverr)
    else $error("unmapped access not flagged");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_irq_level: assert property (|(status_q & mask_q) |=> irq)
    else $error("interrupt not raised");

  cov_ext_skip: cover property (ex && op == OP_SKIP_EXT && ext_q ##1 skip_req);
  cov_pin_skip: cover property (ex && op == OP_SKIP_PIN ##1 skip_req);
  cov_timer_skip: cover property (ex && op == OP_SKIP_TA && ta_q ##1 skip_req);
  cov_suppressed: cover property (skip_req ##[0:4] instr_valid);
  cov_irq: cover property (irq);

endmodule

// File: verification/core_model.sv
`timescale 1ns/1ps
module core_model (
  input wire logic core_clk, // core instruction clock
  input wire logic rst, // synchronous reset, active high
  input irq_timer_pkg::acc_wr_t acc_wr, // accumulator write request
  input wire logic skip_req, // skip request from the block
  output logic instr_valid, // instruction offered
  output logic [irq_timer_pkg::INSTR_W-1:0] instr, // instruction code
  output logic [irq_timer_pkg::ACC_W-1:0] acc_in // accumulator contents
);
  import irq_timer_pkg::*;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] load_v;
  logic load_pend;
  assign acc_in = acc_q;
  initial begin
    instr_valid = 1'b0;
    instr = 10'h155;
    load_pend = 1'b0;
    load_v = 4'h0;
  end
  // masked merge keeps the upper bits on a two-bit transfer; a bench load goes first
  always @(posedge core_clk) begin
    if (rst) begin
      acc_q <= 4'h0;
    end else if (load_pend) begin
      acc_q <= load_v;
    end else if (acc_wr.wr) begin
      acc_q <= (acc_q & ~acc_wr.wmask) | (acc_wr.wdata & acc_wr.wmask);
    end
  end
  task automatic set_acc(input logic [ACC_W-1:0] v);
    @(posedge core_clk);
    load_v <= v;
    load_pend <= 1'b1;
    @(posedge core_clk);
    load_pend <= 1'b0;
  endtask
  // one instruction; skip request taken in its answer cycle, and any
  // accumulator transfer has merged by the edge at which the task returns
  task automatic issue(input logic [INSTR_W-1:0] code, output logic skipped);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr <= code;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    instr <= ~code;
    @(posedge core_clk);
    skipped = skip_req;
    @(posedge core_clk);
  endtask
endmodule

// File: verification/tb_irq_timer_ctrl_instr_exec.sv
`timescale 1ns/1ps
module tb_irq_timer_ctrl_instr_exec;
  import irq_timer_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] setv = 3'h0;
  logic ext_pin = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, skip_req, gie, sk, er, instr_valid;
  wire [2:0] flags;
  logic [3:0] acc_in, v;
  logic [9:0] instr;
  acc_wr_t acc_wr;
  ctl_regs_t ctl_regs;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [9:0] WR[5] = '{CODE_WR_IC_A, CODE_WR_IC_B, CODE_WR_TC_A, CODE_WR_TC_B, CODE_WR_TC_C};
  localparam logic [9:0] RD[5] = '{CODE_RD_IC_A, CODE_RD_IC_B, CODE_RD_TC_A, CODE_RD_TC_B, CODE_RD_TC_C};
  localparam logic [9:0] SK[3] = '{CODE_SKIP_EXT, CODE_SKIP_TA, CODE_SKIP_TB};
  localparam logic [2:0] PIN_CASE[4] = '{3'b001, 3'b010, 3'b111, 3'b100};

  always #5 core_clk = ~core_clk;

  irq_timer_ctrl_instr_exec irq_timer_ctrl_instr_exec_i (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .acc_in(acc_in),
    .ext_request_set(setv[0]), .timer_a_set(setv[1]), .timer_b_set(setv[2]), .ext_pin(ext_pin),
    .acc_wr(acc_wr), .skip_req(skip_req), .irq_global_enable(gie), .ext_request_flag(flags[0]),
    .timer_a_flag(flags[1]), .timer_b_flag(flags[2]), .ctl_regs(ctl_regs), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq)
  );

  core_model core_model_i (
    .core_clk(core_clk), .rst(rst), .acc_wr(acc_wr), .skip_req(skip_req),
    .instr_valid(instr_valid), .instr(instr), .acc_in(acc_in)
  );

  function automatic logic [3:0] fld(input int i);
    case (i)
      0: return ctl_regs.irq_control_a;
      1: return ctl_regs.irq_control_b;
      2: return ctl_regs.timer_control_a;
      3: return ctl_regs.timer_control_b;
      default: return {2'h0, ctl_regs.timer_control_c};
    endcase
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 4000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, OFF_CONTROL, 32'h0);
    chk("control reset", 32'h1, rd);
    apb(1'b0, OFF_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'b0, OFF_STATE, 32'h0);
    chk("state reset", 32'h0, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    core_model_i.issue(CODE_IRQ_UNMASK, sk);
    chk("gie set", 32'h1, 32'(gie));
    apb(1'b0, OFF_STATE, 32'h0);
    chk("state gie", 32'h1, rd);
    chk("mapped no error", 32'h0, 32'(er));
    core_model_i.issue(CODE_IRQ_MASK, sk);
    chk("gie clear", 32'h0, 32'(gie));
    for (int i = 0; i < 5; i++) begin
      v = 4'ha - 4'(i);
      core_model_i.set_acc(v);
      core_model_i.issue(WR[i], sk);
      chk("ctl write", 32'((i == 4) ? {2'h0, v[1:0]} : v), 32'(fld(i)));
      core_model_i.set_acc(4'hd);
      core_model_i.issue(RD[i], sk);
      chk("acc read", 32'((i == 4) ? {2'h3, v[1:0]} : v), 32'(acc_in));
    end
    apb(1'b0, OFF_CTL_VIEW, 32'h0);
    chk("ctl view", 32'h0002789a, rd);
    for (int j = 0; j < 3; j++) begin
      core_model_i.issue(SK[j], sk);
      chk("no skip on clear flag", 32'h0, 32'(sk));
      @(posedge core_clk);
      setv[j] <= 1'b1;
      @(posedge core_clk);
      setv[j] <= 1'b0;
      @(posedge core_clk);
      core_model_i.issue(SK[j], sk);
      chk("skip on set flag", 32'h1, 32'(sk));
      chk("flag cleared", 32'h0, 32'(flags[j]));
      core_model_i.set_acc(4'h5);
      core_model_i.issue(CODE_WR_IC_A, sk);
      chk("skipped write", 32'ha, 32'(ctl_regs.irq_control_a));
    end
    @(posedge core_clk);
    setv[0] <= 1'b1;
    @(posedge core_clk);
    setv[0] <= 1'b0;
    fork
      core_model_i.issue(CODE_SKIP_EXT, sk);
      begin
        @(posedge core_clk);
        setv[0] <= 1'b1;
        @(posedge core_clk);
        setv[0] <= 1'b0;
      end
    join
    chk("skip with new event", 32'h1, 32'(sk));
    chk("new event kept", 32'h1, 32'(flags[0]));
    core_model_i.issue(10'h000, sk);
    core_model_i.issue(CODE_SKIP_EXT, sk);
    chk("flag cleared later", 32'h0, 32'(flags[0]));
    core_model_i.issue(10'h000, sk);
    foreach (PIN_CASE[k]) begin
      core_model_i.set_acc({1'b0, PIN_CASE[k][2], 2'b01});
      core_model_i.issue(CODE_WR_IC_B, sk);
      ext_pin <= PIN_CASE[k][1];
      repeat (6) @(posedge core_clk);
      core_model_i.issue(CODE_SKIP_PIN, sk);
      chk("pin skip", 32'(PIN_CASE[k][0]), 32'(sk));
      core_model_i.issue(10'h000, sk);
    end
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk("status", 32'h7, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq raised", 32'h1, 32'(irq));
    apb(1'b1, OFF_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk("status cleared", 32'h0, rd);
    apb(1'b1, OFF_CONTROL, 32'h0);
    core_model_i.issue(CODE_IRQ_UNMASK, sk);
    chk("exec disabled", 32'h0, 32'(gie));
    end_sim();
  end
endmodule
